/* File: include/sdbp_regs.vh */
`ifndef SDBP_REGS_VH
`define SDBP_REGS_VH

// Command/address bus width and field positions (rising half, except SDBP_CA_AP on the falling half)
`define SDBP_CA_W       10
`define SDBP_CA_RD      2
`define SDBP_CA_AB      4
`define SDBP_CA_BA0     7
`define SDBP_CA_BA1     8
`define SDBP_CA_AP      0

// Opcodes on CA[3:0] and CA[1:0]
`define SDBP_OP_BST     4'h3
`define SDBP_OP_PRE     4'hb
`define SDBP_OP_RW      2'h1

// Burst length codes and their half lengths in clock cycles
`define SDBP_BL_4       2'h0
`define SDBP_BL_8       2'h1
`define SDBP_BL_16      2'h2
`define SDBP_HALF_4     6'h02
`define SDBP_HALF_8     6'h04
`define SDBP_HALF_16    6'h08

// Fixed terms of the precharge timing equations, in clock cycles
`define SDBP_RTP_OFS    6'h02
`define SDBP_WR_OFS     6'h01

// Banks
`define SDBP_NUM_BANKS  4
`define SDBP_ALL_BANKS  4'hf
`define SDBP_AGE_MAX    6'h3f

`endif

/* File: hdl/sdbp_sync2.v */
`timescale 1ns/1ps
// Two-stage synchroniser for pin inputs
module sdbp_sync2 #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input  wire             clk,
   input  wire             rst_b,
   // Data
   input  wire [WIDTH-1:0] din,
   output reg  [WIDTH-1:0] dout
);

   reg [WIDTH-1:0] stage1;

   // Only the second stage is visible outside
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= {WIDTH{1'b0}};
         dout   <= {WIDTH{1'b0}};
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end

endmodule

/* File: hdl/sdbp_burst_ctrl.v */
`timescale 1ns/1ps
// Operation
// - Chip select low with CA3..CA0 = 0011 at rising edge is burst terminate.
// - Truncated burst length is twice the cycles from command to terminate.
// - Terminate affects only the most recent read or write.
// - Read data stops read latency after the terminate edge.
// - Write data acceptance stops write latency after the terminate edge.
// - One mask per byte lane; masked byte stays unwritten for that beat.
// - Mask is input only, sampled on the same strobe edges as data.
// - Chip select low with CA3..CA0 = 1011 at rising edge is precharge.
// - All-bank flag closes every bank, else CA8r/CA7r pick one bank.
// - Auto-close flag on read/write schedules precharge of that bank.
// - Read auto-close starts at later of BL/2 or BL/2-2 plus rtp clocks.
// - Programmed burst length is 4, 8 or 16 beats on strobe edges.
`include "sdbp_regs.vh"
module sdbp_burst_ctrl #(
   parameter DQ_W  = 16,
   parameter DM_W  = 2,
   parameter MAP_W = 32
) (
   // Clock and reset
   input  wire              clk,
   input  wire              rst_b,
   // Command link
   input  wire              ckIn,
   input  wire              csN,
   input  wire [9:0]        caIn,
   // Data link
   input  wire [DQ_W-1:0]   dqIn,
   output reg  [DQ_W-1:0]   dqOut,
   output reg               dqOe,
   input  wire              dqsIn,
   output reg               dqsOut,
   output reg               dqsOe,
   input  wire [DM_W-1:0]   dmIn,
   // Configuration
   input  wire [1:0]        burstLenCode,
   input  wire [3:0]        readLatency,
   input  wire [3:0]        writeLatency,
   input  wire [3:0]        rtpClocks,
   input  wire [3:0]        wrClocks,
   // Array side
   input  wire [3:0]        bankActivate,
   output reg  [3:0]        bankOpen,
   output wire [3:0]        prechargeStart,
   output wire              rdBeatReq,
   input  wire [DQ_W-1:0]   rdData,
   output reg               wrBeatValid,
   output reg  [DQ_W-1:0]   wrBeatData,
   output reg  [DM_W-1:0]   wrBeatMask,
   // Status
   output reg  [5:0]        effBurstLen,
   output reg               bstRefused
);

   localparam SYNC_W = 3 + `SDBP_CA_W + DM_W + DQ_W;

   // Half burst length in clock cycles from the programmed code
   function [5:0] blHalf;
      input [1:0] code;
      begin
         case (code)
            `SDBP_BL_8:  blHalf = `SDBP_HALF_8;
            `SDBP_BL_16: blHalf = `SDBP_HALF_16;
            default:     blHalf = `SDBP_HALF_4;
         endcase
      end
   endfunction

   // Opcode match with chip select
   function cmdIs;
      input       selN;
      input [9:0] ca;
      input [3:0] code;
      begin
         cmdIs = ~selN & (ca[3:0] == code);
      end
   endfunction

   // Run of n ones starting at bit lo
   function [MAP_W-1:0] spanMask;
      input [5:0] lo;
      input [5:0] n;
      begin
         spanMask = (~({MAP_W{1'b1}} << n)) << lo;
      end
   endfunction

   // Every pin input crosses into clk before use
   wire [SYNC_W-1:0] syncOut;
   wire              ckS;
   wire              dqsS;
   wire              csNS;
   wire [9:0]        caS;
   wire [DM_W-1:0]   dmS;
   wire [DQ_W-1:0]   dqS;

   sdbp_sync2 #(
      .WIDTH (SYNC_W)
   ) uSync (
      .clk   (clk),
      .rst_b (rst_b),
      .din   ({ckIn, dqsIn, csN, caIn, dmIn, dqIn}),
      .dout  (syncOut)
   );

   assign {ckS, dqsS, csNS, caS, dmS, dqS} = syncOut;

   reg         ckPrev;
   reg         dqsPrev;
   reg         csRise;
   reg [9:0]   caRise;

   wire ckRise  = ckS & ~ckPrev;
   wire ckFall  = ~ckS & ckPrev;
   wire dqsEdge = dqsS ^ dqsPrev;

   // Edge history and rising-half command capture
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ckPrev  <= 1'b0;
         dqsPrev <= 1'b0;
         csRise  <= 1'b1;
         caRise  <= 10'h000;
      end else begin
         ckPrev  <= ckS;
         dqsPrev <= dqsS;
         if (ckRise) begin
            csRise <= csNS;
            caRise <= caS;
         end
      end
   end

   // Decode once both halves are in, at the falling edge
   wire isBst  = ckFall & cmdIs(csRise, caRise, `SDBP_OP_BST);
   wire isPre  = ckFall & cmdIs(csRise, caRise, `SDBP_OP_PRE);
   wire isRw   = ckFall & ~csRise & (caRise[1:0] == `SDBP_OP_RW);
   wire cmdRd  = caRise[`SDBP_CA_RD];
   wire cmdAp  = caS[`SDBP_CA_AP];
   wire [1:0] cmdBank = {caRise[`SDBP_CA_BA1], caRise[`SDBP_CA_BA0]};

   wire [5:0] curHalf = blHalf(burstLenCode);
   wire [5:0] rdLat   = {2'h0, readLatency};
   wire [5:0] wrLat   = {2'h0, writeLatency};

   // Most recent read or write; earlier bursts are never touched
   reg        recentValid;
   reg        recentRead;
   reg        recentAp;
   reg        bstUsed;
   reg [5:0]  recentAge;
   reg [5:0]  recentHalf;
   reg [5:0]  recentLat;

   wire bstOk = isBst & recentValid & ~bstUsed & ~recentAp
              & (recentAge != 6'h00) & (recentAge < recentHalf)
              & ~recentAge[0];

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         recentValid <= 1'b0;
         recentRead  <= 1'b0;
         recentAp    <= 1'b0;
         bstUsed     <= 1'b0;
         recentAge   <= 6'h00;
         recentHalf  <= `SDBP_HALF_4;
         recentLat   <= 6'h00;
         effBurstLen <= 6'h00;
         bstRefused  <= 1'b0;
      end else begin
         bstRefused <= isBst & ~bstOk;
         if (isRw) begin
            recentValid <= 1'b1;
            recentRead  <= cmdRd;
            recentAp    <= cmdAp;
            bstUsed     <= 1'b0;
            recentAge   <= 6'h00;
            recentHalf  <= curHalf;
            recentLat   <= cmdRd ? rdLat : wrLat;
            effBurstLen <= {curHalf[4:0], 1'b0};
         end else begin
            if (ckRise && recentAge != `SDBP_AGE_MAX) begin
               recentAge <= recentAge + 6'h01;
            end
            if (bstOk) begin
               bstUsed     <= 1'b1;
               effBurstLen <= {recentAge[4:0], 1'b0};
            end
         end
      end
   end

   // Data-cycle maps: bit k marks a data cycle k clocks from now
   reg [MAP_W-1:0] rdMap;
   reg [MAP_W-1:0] wrMap;
   reg [MAP_W-1:0] next_rdMap;
   reg [MAP_W-1:0] next_wrMap;

   always @* begin
      next_rdMap = ckRise ? {1'b0, rdMap[MAP_W-1:1]} : rdMap;
      next_wrMap = ckRise ? {1'b0, wrMap[MAP_W-1:1]} : wrMap;
      if (isRw && cmdRd) begin
         next_rdMap = next_rdMap | spanMask(rdLat, curHalf);
      end
      if (isRw && !cmdRd) begin
         next_wrMap = next_wrMap | spanMask(wrLat, curHalf);
      end
      // Clearing beyond the latency cuts only the latest burst
      if (bstOk && recentRead) begin
         next_rdMap = next_rdMap & ~({MAP_W{1'b1}} << recentLat);
      end
      if (bstOk && !recentRead) begin
         next_wrMap = next_wrMap & ~({MAP_W{1'b1}} << recentLat);
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdMap <= {MAP_W{1'b0}};
         wrMap <= {MAP_W{1'b0}};
      end else begin
         rdMap <= next_rdMap;
         wrMap <= next_wrMap;
      end
   end

   // A beat on each clock edge of a data cycle
   wire readBeat = (ckRise & rdMap[1]) | (ckFall & rdMap[0]);
   assign rdBeatReq = readBeat;

   // Read drive; tDQSCK is taken as zero at this sample rate
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dqOut  <= {DQ_W{1'b0}};
         dqOe   <= 1'b0;
         dqsOut <= 1'b0;
         dqsOe  <= 1'b0;
      end else if (readBeat) begin
         dqOut  <= rdData;
         dqOe   <= 1'b1;
         dqsOut <= ckRise;
         dqsOe  <= 1'b1;
      end else if (ckRise && !rdMap[1]) begin
         dqOe   <= 1'b0;
         dqsOut <= 1'b0;
         dqsOe  <= 1'b0;
      end
   end

   // Strobe edge coinciding with a clock rise belongs to the new cycle
   wire wrOpen   = ckRise ? wrMap[1] : wrMap[0];
   wire wrAccept = dqsEdge & wrOpen;

   // Data and mask caught on the same strobe edge
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wrBeatValid <= 1'b0;
         wrBeatData  <= {DQ_W{1'b0}};
         wrBeatMask  <= {DM_W{1'b0}};
      end else begin
         wrBeatValid <= wrAccept;
         if (wrAccept) begin
            wrBeatData <= dqS;
            wrBeatMask <= dmS;
         end
      end
   end

   // Precharge bank select
   wire [3:0] preSel = caRise[`SDBP_CA_AB] ? `SDBP_ALL_BANKS
                                          : (4'h1 << cmdBank);

   // Auto-close delays counted in clock cycles from the command
   wire [5:0] rtpExtra   = ({2'h0, rtpClocks} > `SDBP_RTP_OFS)
                         ? ({2'h0, rtpClocks} - `SDBP_RTP_OFS) : 6'h00;
   wire [5:0] rdApDelay  = curHalf + rtpExtra;
   wire [5:0] wrApDelay  = wrLat + curHalf + `SDBP_WR_OFS + {2'h0, wrClocks};
   wire [5:0] apDelay    = cmdRd ? rdApDelay : wrApDelay;

   // Per-bank auto-close timers; a new command to another bank leaves them
   genvar b;
   generate
      for (b = 0; b < `SDBP_NUM_BANKS; b = b + 1) begin : gBank
         reg       apArm;
         reg [5:0] apCnt;
         reg       pcs;
         wire      apLoad = isRw & cmdAp & ({30'h0, cmdBank} == b);
         wire      apFire = ckRise & apArm & (apCnt == 6'h01);

         always @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               apArm <= 1'b0;
               apCnt <= 6'h00;
               pcs   <= 1'b0;
            end else begin
               pcs <= apFire | (isPre & preSel[b]);
               if (apLoad) begin
                  apArm <= 1'b1;
                  apCnt <= apDelay;
               end else if (apFire) begin
                  apArm <= 1'b0;
               end else if (ckRise && apArm) begin
                  apCnt <= apCnt - 6'h01;
               end
            end
         end

         assign prechargeStart[b] = pcs;
      end
   endgenerate

   // Bank open state; activate wins over a same-cycle precharge
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bankOpen <= 4'h0;
      end else begin
         bankOpen <= (bankOpen & ~prechargeStart) | bankActivate;
      end
   end

endmodule

/* File: verification/sdbp_chk.sv */
`timescale 1ns/1ps
module sdbp_chk #(
   parameter DQ_W  = 16,
   parameter DM_W  = 2,
   parameter MAP_W = 32
) (
   // Clock and reset
   input wire            clk,
   input wire            rst_b,
   // Array side
   input wire [3:0]      bankActivate,
   input wire [3:0]      bankOpen,
   input wire [3:0]      prechargeStart,
   input wire            rdBeatReq,
   input wire [DQ_W-1:0] rdData,
   input wire            wrBeatValid,
   input wire [DQ_W-1:0] wrBeatData,
   input wire [DM_W-1:0] wrBeatMask,
   // Data pins and status
   input wire [DQ_W-1:0] dqOut,
   input wire            dqOe,
   input wire            dqsOut,
   input wire            dqsOe,
   input wire [5:0]      effBurstLen,
   input wire            bstRefused
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Bank closing; an activate in the same clk wins, so it is left out
   pre_closes_bank_a:
      assert property (prechargeStart != 4'h0 && bankActivate == 4'h0 |=>
         (bankOpen & $past(prechargeStart)) == 4'h0) else $error("bank left open");
   pre_pulse_one_a:
      assert property (prechargeStart != 4'h0 |=>
         (prechargeStart & $past(prechargeStart)) == 4'h0) else $error("long precharge pulse");
   // Read beats reach the pins one clk after the array request
   rd_beat_data_a:
      assert property (rdBeatReq |=> dqOe && dqOut == $past(rdData))
         else $error("read beat not driven");
   rd_strobe_flip_a:
      assert property (rdBeatReq |=> dqsOut != $past(dqsOut)) else $error("strobe did not flip");
   rd_oe_pair_a:
      assert property (dqOe == dqsOe) else $error("data and strobe enables differ");
   // Write beats are single pulses and their data holds in between
   wr_beat_one_a:
      assert property (wrBeatValid |=> !wrBeatValid) else $error("write beat too long");
   wr_beat_hold_a:
      assert property (!wrBeatValid |-> $stable(wrBeatData) && $stable(wrBeatMask))
         else $error("write beat changed without strobe");
   eff_len_quad_a:
      assert property (effBurstLen[1:0] == 2'h0) else $error("burst length not a multiple of 4");
   refuse_pulse_a:
      assert property (bstRefused |=> !bstRefused) else $error("refusal pulse too long");
endmodule

bind sdbp_burst_ctrl sdbp_chk #(.DQ_W(DQ_W), .DM_W(DM_W), .MAP_W(MAP_W)) u_chk (
   .clk(clk), .rst_b(rst_b), .bankActivate(bankActivate), .bankOpen(bankOpen),
   .prechargeStart(prechargeStart), .rdBeatReq(rdBeatReq), .rdData(rdData),
   .wrBeatValid(wrBeatValid), .wrBeatData(wrBeatData), .wrBeatMask(wrBeatMask),
   .dqOut(dqOut), .dqOe(dqOe), .dqsOut(dqsOut), .dqsOe(dqsOe),
   .effBurstLen(effBurstLen), .bstRefused(bstRefused)
);

/* File: verification/sdbp_ctl_model.sv */
`timescale 1ns/1ps
module sdbp_ctl_model (
   // Clock
   input  wire        clk,
   // Command link
   output wire        ckIn,
   output reg         csN = 1'b1,
   output reg  [9:0]  caIn = 10'h000,
   // Write data
   output reg         dqsCtl = 1'b0,
   output reg  [15:0] dqCtl = 16'h0000,
   output reg  [1:0]  dmIn = 2'h0
);
   reg [2:0] ph = 3'h0;
   integer   i;
   // Command clock runs free, eight system clocks a period
   always @(posedge clk) ph <= ph + 3'h1;
   assign ckIn = ~ph[2];
   // Each half set up a clk before its ck edge, so the sync pipe catches it
   task cmd(input [9:0] r, input [9:0] f);
      begin
         @(posedge clk iff ph == 3'h6);
         csN <= 1'b0;
         caIn <= r;
         @(posedge clk iff ph == 3'h2);
         caIn <= f;
      end
   endtask
   // Deselected cycles; bus shows the inverse so stale values never pass
   task idle(input integer n);
      repeat (n) begin
         @(posedge clk iff ph == 3'h6);
         csN <= 1'b1;
         caIn <= ~caIn;
      end
   endtask
   // Beats on both ck edges from the cycle after a command started with it (WL 1)
   task wdata(input integer n);
      begin
         @(posedge clk iff ph == 3'h6);
         repeat (2) @(posedge clk iff ph == 3'h7);
         for (i = 0; i < n; i = i + 1) begin
            dqsCtl <= ~dqsCtl;
            dqCtl <= 16'h1000 + i[15:0];
            dmIn <= i[1:0];
            @(posedge clk iff ph[1:0] == 2'h3);
         end
         dqCtl <= ~dqCtl;
         dmIn <= ~dmIn;
      end
   endtask
endmodule

/* File: verification/test_sdram_burst_stop_and_precharge.sv */
`timescale 1ns/1ps
module test_sdram_burst_stop_and_precharge;
   reg         clk = 1'b0;
   reg         rst_b = 1'b0;
   reg  [1:0]  burstLenCode = 2'h1;
   reg  [3:0]  rtpClocks = 4'h2;
   reg  [3:0]  readLatency = 4'h3;
   reg  [3:0]  writeLatency = 4'h1;
   reg  [3:0]  wrClocks = 4'h2;
   reg  [3:0]  bankActivate = 4'h0;
   reg  [7:0]  rdBeats = 8'h00;
   reg  [7:0]  wrBeats = 8'h00;
   reg  [7:0]  refused = 8'h00;
   reg  [7:0]  s;
   integer     fails = 0;
   integer     numChecks = 0;
   integer     b;
   wire        ckIn, csN, dqsCtl, dqsIn, dqOe, dqsOut, dqsOe;
   wire        rdBeatReq, wrBeatValid, bstRefused;
   wire [9:0]  caIn;
   wire [1:0]  dmIn, wrBeatMask;
   wire [3:0]  bankOpen, prechargeStart;
   wire [5:0]  effBurstLen;
   wire [15:0] dqOut, dqCtl, dqIn, rdData, wrBeatData;

   always #50 clk = ~clk;
   // Shared pins: whoever enables drives
   assign dqIn = dqOe ? dqOut : dqCtl;
   assign dqsIn = dqsOe ? dqsOut : dqsCtl;
   assign rdData = {8'ha5, rdBeats};
   // Tallies of array beats and refused terminates
   always @(posedge clk) begin
      rdBeats <= rdBeats + rdBeatReq;
      wrBeats <= wrBeats + wrBeatValid;
      refused <= refused + bstRefused;
   end

   sdbp_ctl_model u_ctl (.clk(clk), .ckIn(ckIn), .csN(csN), .caIn(caIn),
      .dqsCtl(dqsCtl), .dqCtl(dqCtl), .dmIn(dmIn));
   sdbp_burst_ctrl u_dut (.clk(clk), .rst_b(rst_b), .ckIn(ckIn), .csN(csN), .caIn(caIn),
      .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .dqsIn(dqsIn), .dqsOut(dqsOut),
      .dqsOe(dqsOe), .dmIn(dmIn), .burstLenCode(burstLenCode), .readLatency(readLatency),
      .writeLatency(writeLatency), .rtpClocks(rtpClocks), .wrClocks(wrClocks),
      .bankActivate(bankActivate), .bankOpen(bankOpen), .prechargeStart(prechargeStart),
      .rdBeatReq(rdBeatReq), .rdData(rdData), .wrBeatValid(wrBeatValid),
      .wrBeatData(wrBeatData), .wrBeatMask(wrBeatMask), .effBurstLen(effBurstLen),
      .bstRefused(bstRefused));

   task chk(input [15:0] seen, input [15:0] exp);
      begin
         numChecks = numChecks + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask

   task results;
      begin
         if (fails == 0 && numChecks > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask

   task openAll;
      begin
         bankActivate <= 4'hf;
         @(posedge clk);
         bankActivate <= 4'h0;
      end
   endtask

   // Hang guard, several times the expected run
   initial begin
      #300000;
      fails = fails + 1;
      results;
   end

   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      repeat (5) @(posedge clk);
      openAll;
      // Full BL8 read
      s = rdBeats;
      u_ctl.cmd(10'h005, 10'h000);
      u_ctl.idle(8);
      chk(rdBeats - s, 16'h0008);
      chk(effBurstLen, 16'h0008);
      chk(dqOut, {8'ha5, s + 8'h07});
      chk(dqOe, 16'h0000);
      // BL16 read cut at age 2, then a second terminate
      burstLenCode <= 2'h2;
      s = rdBeats;
      u_ctl.cmd(10'h005, 10'h000);
      u_ctl.idle(1);
      u_ctl.cmd(10'h003, 10'h000);
      u_ctl.cmd(10'h003, 10'h000);
      u_ctl.idle(6);
      chk(rdBeats - s, 16'h0004);
      chk(effBurstLen, 16'h0004);
      chk(refused, 16'h0001);
      // Odd-age terminate is ignored, burst runs whole
      s = rdBeats;
      u_ctl.cmd(10'h005, 10'h000);
      u_ctl.cmd(10'h003, 10'h000);
      u_ctl.idle(12);
      chk(rdBeats - s, 16'h0010);
      chk(refused, 16'h0002);
      // BL16 write cut at age 4 while strobes keep coming
      s = wrBeats;
      fork
         u_ctl.wdata(16);
         begin
            u_ctl.cmd(10'h001, 10'h000);
            u_ctl.idle(3);
            u_ctl.cmd(10'h003, 10'h000);
            u_ctl.idle(6);
         end
      join
      chk(wrBeats - s, 16'h0008);
      chk(wrBeatData, 16'h1007);
      chk(wrBeatMask, 16'h0003);
      chk(effBurstLen, 16'h0008);
      // BL8 read with auto-close on bank 1; terminate refused, rtp term wins
      burstLenCode <= 2'h1;
      rtpClocks <= 4'h5;
      s = rdBeats;
      u_ctl.cmd(10'h085, 10'h001);
      u_ctl.idle(1);
      u_ctl.cmd(10'h003, 10'h000);
      u_ctl.idle(5);
      chk(bankOpen, 16'h000f);
      u_ctl.idle(1);
      chk(bankOpen, 16'h000d);
      chk(rdBeats - s, 16'h0008);
      chk(refused, 16'h0003);
      // BL4 write with auto-close on bank 2; closes WL + BL/2 + 1 + wr cycles on
      burstLenCode <= 2'h0;
      s = wrBeats;
      fork
         u_ctl.wdata(4);
         begin
            u_ctl.cmd(10'h101, 10'h001);
            u_ctl.idle(6);
            chk(bankOpen, 16'h000d);
            u_ctl.idle(1);
            chk(bankOpen, 16'h0009);
         end
      join
      chk(wrBeats - s, 16'h0004);
      // Every single bank, then all banks
      for (b = 0; b < 5; b = b + 1) begin
         openAll;
         u_ctl.cmd(b < 4 ? {1'b0, b[1:0], 7'h0b} : 10'h01b, 10'h000);
         u_ctl.idle(2);
         chk(bankOpen, b < 4 ? 4'hf ^ (4'h1 << b[1:0]) : 4'h0);
      end
      results;
   end
endmodule
